/* frsc_regs.vh */
`ifndef FRSC_REGS_VH
`define FRSC_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the control port)
// ----------------------------------------------------------------------------
`define FRSC_OFS_RX_SETTLE_DELAY   10'h109
`define FRSC_OFS_SETTLE_EXT        10'h10B
`define FRSC_OFS_RADIO_CTRL        10'h13E
`define FRSC_OFS_BIT_RATE_HIGH     10'h30E
`define FRSC_OFS_BIT_RATE_LOW      10'h30F
`define FRSC_OFS_CHAN_FILTER       10'h389
`define FRSC_OFS_POST_DISC         10'h38B
`define FRSC_OFS_RX_FRONT_END      10'h39B

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define FRSC_RST_RX_SETTLE_DELAY   8'hC0
`define FRSC_RST_SETTLE_EXT        8'h00
`define FRSC_RST_RADIO_CTRL        8'h00
`define FRSC_RST_BIT_RATE_HIGH     8'h00
`define FRSC_RST_BIT_RATE_LOW      8'h00
`define FRSC_RST_CHAN_FILTER       8'h00
`define FRSC_RST_POST_DISC         8'h00
`define FRSC_RST_RX_FRONT_END      8'h00
`define FRSC_RST_ANA_BW            4'h0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FRSC_CHAN_FIRST_LSB        0
`define FRSC_CHAN_FIRST_MSB        1
`define FRSC_CHAN_SECOND_LSB       2
`define FRSC_CHAN_SECOND_MSB       4
`define FRSC_ANA_BW_LSB            0
`define FRSC_ANA_BW_MSB            3
`define FRSC_MODE_FSK              8'h03

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FRSC_CLK_PERIOD_NS         10
`define FRSC_US_NS                 1000
`define FRSC_US_CYCLES             (`FRSC_US_NS / `FRSC_CLK_PERIOD_NS)
`define FRSC_CAL_TIME_US           11'h298
`define FRSC_EXT_STEP_SHIFT        2
`define FRSC_SYNC_SEARCH_BYTES     4
`define FRSC_BITS_PER_BYTE         8
`define FRSC_SYNC_SEARCH_BITS      (`FRSC_SYNC_SEARCH_BYTES * `FRSC_BITS_PER_BYTE)

`endif

/* frsc_us_tick.v */
`timescale 1ns/1ps
`default_nettype none

module frsc_us_tick #(
    parameter CYCLES = 100
) (
    // Clock and reset
    input  wire        sys_clk_in,
    input  wire        rst_in,
    // Control
    input  wire        restart_in,
    output reg         tick_out
);
    reg  [15:0] cnt_q;

    // Restart aligns the microsecond grid with the receive-entry command
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q    <= 16'h0000;
            tick_out <= 1'b0;
        end else if (restart_in) begin
            cnt_q    <= 16'h0000;
            tick_out <= 1'b0;
        end else if (cnt_q == CYCLES[15:0] - 16'h0001) begin
            cnt_q    <= 16'h0000;
            tick_out <= 1'b1;
        end else begin
            cnt_q    <= cnt_q + 16'h0001;
            tick_out <= 1'b0;
        end
    end
endmodule // frsc_us_tick

`default_nettype wire

/* frsc_bw_lut.v */
`timescale 1ns/1ps
`default_nettype none

module frsc_bw_lut (
    // Code in, bandwidth in kHz out
    input  wire [3:0]  code_in,
    output reg  [10:0] khz_out
);
    // Codes below 6 clamp to the narrowest setting, 15 to the widest
    always @* begin
        case (code_in)
            4'h7:    khz_out = 11'd655;
            4'h8:    khz_out = 11'd730;
            4'h9:    khz_out = 11'd797;
            4'hA:    khz_out = 11'd867;
            4'hB:    khz_out = 11'd927;
            4'hC:    khz_out = 11'd991;
            4'hD:    khz_out = 11'd1029;
            4'hE:    khz_out = 11'd1126;
            4'hF:    khz_out = 11'd1126;
            default: khz_out = 11'd555;
        endcase
    end
endmodule // frsc_bw_lut

`default_nettype wire

/* frsc_rx_seq.v */
// Functional notes
// - Every receive-entry command runs the full receive calibration sequence.
// - Frequency-shift-keying receive calibration lasts 664 us from the command.
// - Extension code 0x76 gives 664 us total settle, ready event at end.
// - After settle delay, enter receive and search for preamble and sync.
// - Start-of-frame event, when enabled, follows qualified preamble plus sync match.
// - Serial port mode never raises packet-received; framing output marks sync.
// - Receive state holds until host commands another state.
// - FSK mode: offset-cancel loop runs during calibration only, then frozen.
// - 250 kbps packet mode: offset-cancel loop runs continuously.
// - Analog baseband bandwidth takes effect only on idle to standby.
// - Analog bandwidth codes 6 to 14 span 555 kHz to 1126 kHz.
// - Channel filter uses two-bit first and three-bit second stage fields.
// - Post-discriminator bandwidth is a full eight-bit field.
// - Bit recovery rate is sixteen bits from high and low byte registers.
// - Bit recovery tolerates three percent rate error on alternating preamble.
// - Bit recovery locks within five preamble transitions.
// - Sync search lasts four bytes, then releases locks, back to preamble.
`timescale 1ns/1ps
`default_nettype none
`include "frsc_regs.vh"

module frsc_rx_seq #(
    parameter US_CYCLES   = `FRSC_US_CYCLES,
    parameter SYNC_BITS   = `FRSC_SYNC_SEARCH_BITS
) (
    // Clock and reset
    input  wire        sys_clk_in,
    input  wire        rst_in,
    // Control port register access
    input  wire [9:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [7:0]  reg_rdata_out,
    output reg         reg_rvalid_out,
    // Host state commands
    input  wire        receive_entry_command_in,
    input  wire        cmd_idle_in,
    input  wire        cmd_phy_standby_in,
    // Receive path configuration and status from neighbouring logic
    input  wire        serial_data_port_en_in,
    input  wire        sof_event_enable_in,
    input  wire        preamble_qualified_in,
    input  wire        sync_match_in,
    input  wire        bit_strobe_in,
    input  wire        packet_done_in,
    // Sequencing outputs
    output reg  [1:0]  state_out,
    output reg         rx_state_out,
    output reg         calibrating_out,
    output reg         settle_done_event_out,
    output reg         offset_cancel_loop_run_out,
    output reg         preamble_search_out,
    output reg         sync_search_out,
    output reg         lock_release_out,
    output reg         start_of_frame_event_out,
    output reg         framing_sync_output_out,
    output reg         packet_received_event_out,
    // Filter and recovery settings
    output reg  [3:0]  analog_baseband_bandwidth_out,
    output reg  [10:0] analog_bb_bw_khz_out,
    output reg  [1:0]  channel_filter_first_bw_out,
    output reg  [2:0]  channel_filter_second_bw_out,
    output reg  [7:0]  post_discriminator_bandwidth_out,
    output reg  [15:0] bit_recovery_rate_out
);
    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam [1:0] ST_IDLE    = 2'b00;
    localparam [1:0] ST_STANDBY = 2'b01;
    localparam [1:0] ST_SETTLE  = 2'b10;
    localparam [1:0] ST_RX      = 2'b11;

    localparam [1:0] SR_PREAMBLE = 2'b00;
    localparam [1:0] SR_SYNC     = 2'b01;
    localparam [1:0] SR_FRAME    = 2'b10;

    // ------------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------------
    reg  [7:0]  settle_delay_q;
    reg  [7:0]  settle_ext_q;
    reg  [7:0]  radio_ctrl_q;
    reg  [7:0]  rate_high_q;
    reg  [7:0]  rate_low_q;
    reg  [7:0]  chan_filter_q;
    reg  [7:0]  post_disc_q;
    reg  [7:0]  front_end_q;
    reg  [7:0]  rdata_d;

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            settle_delay_q <= `FRSC_RST_RX_SETTLE_DELAY;
            settle_ext_q   <= `FRSC_RST_SETTLE_EXT;
            radio_ctrl_q   <= `FRSC_RST_RADIO_CTRL;
            rate_high_q    <= `FRSC_RST_BIT_RATE_HIGH;
            rate_low_q     <= `FRSC_RST_BIT_RATE_LOW;
            chan_filter_q  <= `FRSC_RST_CHAN_FILTER;
            post_disc_q    <= `FRSC_RST_POST_DISC;
            front_end_q    <= `FRSC_RST_RX_FRONT_END;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `FRSC_OFS_RX_SETTLE_DELAY: settle_delay_q <= reg_wdata_in;
                `FRSC_OFS_SETTLE_EXT:      settle_ext_q   <= reg_wdata_in;
                `FRSC_OFS_RADIO_CTRL:      radio_ctrl_q   <= reg_wdata_in;
                `FRSC_OFS_BIT_RATE_HIGH:   rate_high_q    <= reg_wdata_in;
                `FRSC_OFS_BIT_RATE_LOW:    rate_low_q     <= reg_wdata_in;
                `FRSC_OFS_CHAN_FILTER:     chan_filter_q  <= reg_wdata_in;
                `FRSC_OFS_POST_DISC:       post_disc_q    <= reg_wdata_in;
                `FRSC_OFS_RX_FRONT_END:    front_end_q    <= reg_wdata_in;
                default: begin
                end
            endcase
        end
    end

    // Unmapped offsets read as zero
    always @* begin
        case (reg_addr_in)
            `FRSC_OFS_RX_SETTLE_DELAY: rdata_d = settle_delay_q;
            `FRSC_OFS_SETTLE_EXT:      rdata_d = settle_ext_q;
            `FRSC_OFS_RADIO_CTRL:      rdata_d = radio_ctrl_q;
            `FRSC_OFS_BIT_RATE_HIGH:   rdata_d = rate_high_q;
            `FRSC_OFS_BIT_RATE_LOW:    rdata_d = rate_low_q;
            `FRSC_OFS_CHAN_FILTER:     rdata_d = chan_filter_q;
            `FRSC_OFS_POST_DISC:       rdata_d = post_disc_q;
            `FRSC_OFS_RX_FRONT_END:    rdata_d = front_end_q;
            default:                   rdata_d = 8'h00;
        endcase
    end

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out  <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rdata_out  <= reg_rd_in ? rdata_d : 8'h00;
            reg_rvalid_out <= reg_rd_in;
        end
    end

    // ------------------------------------------------------------------------
    // Microsecond time base
    // ------------------------------------------------------------------------
    wire        us_tick;
    wire        fsk_mode;
    reg  [10:0] us_cnt_q;
    wire [10:0] settle_target;

    assign fsk_mode = (radio_ctrl_q == `FRSC_MODE_FSK);
    // Extension field counts in 4 us steps, so 0x76 adds 472 us to 192 us
    assign settle_target = {3'b000, settle_delay_q}
                         + {1'b0, settle_ext_q, 2'b00};

    frsc_us_tick #(
        .CYCLES     (US_CYCLES)
    ) u_us_tick (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .restart_in (receive_entry_command_in),
        .tick_out   (us_tick)
    );

    // Saturates so a long receive dwell never wraps back into the settle window
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            us_cnt_q <= 11'h000;
        end else if (receive_entry_command_in) begin
            us_cnt_q <= 11'h000;
        end else if (us_tick && us_cnt_q != 11'h7FF) begin
            us_cnt_q <= us_cnt_q + 11'h001;
        end
    end

    // ------------------------------------------------------------------------
    // Main sequencer
    // ------------------------------------------------------------------------
    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg         settle_hit;

    always @* begin
        settle_hit = 1'b0;
        state_d    = state_q;
        if (receive_entry_command_in) begin
            state_d = ST_SETTLE;
        end else if (cmd_idle_in) begin
            state_d = ST_IDLE;
        end else if (cmd_phy_standby_in) begin
            state_d = ST_STANDBY;
        end else begin
            case (state_q)
                ST_SETTLE: begin
                    if (us_cnt_q >= settle_target) begin
                        settle_hit = 1'b1;
                        state_d    = ST_RX;
                    end
                end
                ST_RX:      state_d = ST_RX;
                ST_STANDBY: state_d = ST_STANDBY;
                default:    state_d = ST_IDLE;
            endcase
        end
    end

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q               <= ST_IDLE;
            state_out             <= ST_IDLE;
            rx_state_out          <= 1'b0;
            settle_done_event_out <= 1'b0;
        end else begin
            state_q               <= state_d;
            state_out             <= state_d;
            rx_state_out          <= (state_d == ST_RX);
            settle_done_event_out <= settle_hit;
        end
    end

    // ------------------------------------------------------------------------
    // Calibration window and offset-cancel loop policy
    // ------------------------------------------------------------------------
    reg         cal_q;
    reg         cal_d;
    reg         ocl_run_d;

    // Calibration runs its fixed length even when the settle delay is shorter;
    // leaving receive for idle or standby abandons it
    always @* begin
        cal_d = cal_q;
        if (receive_entry_command_in) begin
            cal_d = 1'b1;
        end else if (cmd_idle_in || cmd_phy_standby_in) begin
            cal_d = 1'b0;
        end else if (us_cnt_q >= `FRSC_CAL_TIME_US) begin
            cal_d = 1'b0;
        end
    end

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cal_q <= 1'b0;
        end else begin
            cal_q <= cal_d;
        end
    end

    // Next-state view so the loop and the window rise on the same edge
    always @* begin
        if (state_d == ST_IDLE || state_d == ST_STANDBY) begin
            ocl_run_d = 1'b0;
        end else if (fsk_mode) begin
            ocl_run_d = cal_d;
        end else begin
            ocl_run_d = 1'b1;
        end
    end

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            calibrating_out            <= 1'b0;
            offset_cancel_loop_run_out <= 1'b0;
        end else begin
            calibrating_out            <= cal_d;
            offset_cancel_loop_run_out <= ocl_run_d;
        end
    end

    // ------------------------------------------------------------------------
    // Preamble and sync search
    // ------------------------------------------------------------------------
    reg  [1:0]  srch_q;
    reg  [5:0]  bit_cnt_q;
    wire        in_rx;
    wire        sync_timeout;

    assign in_rx        = (state_q == ST_RX) && (state_d == ST_RX);
    assign sync_timeout = bit_strobe_in && (bit_cnt_q == SYNC_BITS[5:0] - 6'h01);

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            srch_q                    <= SR_PREAMBLE;
            bit_cnt_q                 <= 6'h00;
            lock_release_out          <= 1'b0;
            start_of_frame_event_out  <= 1'b0;
            framing_sync_output_out   <= 1'b0;
            packet_received_event_out <= 1'b0;
        end else begin
            lock_release_out          <= 1'b0;
            start_of_frame_event_out  <= 1'b0;
            packet_received_event_out <= 1'b0;
            if (!in_rx) begin
                srch_q                  <= SR_PREAMBLE;
                bit_cnt_q               <= 6'h00;
                framing_sync_output_out <= 1'b0;
            end else begin
                case (srch_q)
                    SR_PREAMBLE: begin
                        bit_cnt_q <= 6'h00;
                        if (preamble_qualified_in) begin
                            srch_q <= SR_SYNC;
                        end
                    end
                    SR_SYNC: begin
                        if (sync_match_in) begin
                            srch_q                   <= SR_FRAME;
                            start_of_frame_event_out <= sof_event_enable_in;
                            framing_sync_output_out  <= serial_data_port_en_in;
                        end else if (sync_timeout) begin
                            srch_q           <= SR_PREAMBLE;
                            lock_release_out <= 1'b1;
                        end else if (bit_strobe_in) begin
                            bit_cnt_q <= bit_cnt_q + 6'h01;
                        end
                    end
                    SR_FRAME: begin
                        // Serial port streams until the host leaves receive
                        if (packet_done_in && !serial_data_port_en_in) begin
                            packet_received_event_out <= 1'b1;
                            srch_q                    <= SR_PREAMBLE;
                        end
                    end
                    default: srch_q <= SR_PREAMBLE;
                endcase
            end
        end
    end

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            preamble_search_out <= 1'b0;
            sync_search_out     <= 1'b0;
        end else begin
            preamble_search_out <= in_rx && (srch_q == SR_PREAMBLE);
            sync_search_out     <= in_rx && (srch_q == SR_SYNC);
        end
    end

    // ------------------------------------------------------------------------
    // Filter and bit recovery settings
    // ------------------------------------------------------------------------
    wire [10:0] ana_khz;

    frsc_bw_lut u_bw_lut (
        .code_in (analog_baseband_bandwidth_out),
        .khz_out (ana_khz)
    );

    // Analog bandwidth is a shadow copy, refreshed only on idle to standby
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            analog_baseband_bandwidth_out <= `FRSC_RST_ANA_BW;
            analog_bb_bw_khz_out          <= 11'h000;
        end else begin
            if (state_q == ST_IDLE && state_d == ST_STANDBY) begin
                analog_baseband_bandwidth_out <=
                    front_end_q[`FRSC_ANA_BW_MSB:`FRSC_ANA_BW_LSB];
            end
            analog_bb_bw_khz_out <= ana_khz;
        end
    end

    // Bit recovery loop itself lives in the demodulator; the rate word
    // it tracks with is what sets its tolerance and lock time
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            channel_filter_first_bw_out      <= 2'b00;
            channel_filter_second_bw_out     <= 3'b000;
            post_discriminator_bandwidth_out <= 8'h00;
            bit_recovery_rate_out            <= 16'h0000;
        end else begin
            channel_filter_first_bw_out  <=
                chan_filter_q[`FRSC_CHAN_FIRST_MSB:`FRSC_CHAN_FIRST_LSB];
            channel_filter_second_bw_out <=
                chan_filter_q[`FRSC_CHAN_SECOND_MSB:`FRSC_CHAN_SECOND_LSB];
            post_discriminator_bandwidth_out <= post_disc_q;
            bit_recovery_rate_out <= {rate_high_q, rate_low_q};
        end
    end

endmodule // frsc_rx_seq

`default_nettype wire

/* frsc_rx_seq_props.sv */
`timescale 1ns/1ps
`default_nettype none
module frsc_rx_seq_chk (
    input wire logic       sys_clk_in,
    input wire logic       rst_in,
    input wire logic       receive_entry_command_in,
    input wire logic       cmd_idle_in,
    input wire logic       cmd_phy_standby_in,
    input wire logic       serial_data_port_en_in,
    input wire logic       sof_event_enable_in,
    input wire logic       sync_match_in,
    input wire logic       bit_strobe_in,
    input wire logic [1:0] state_out,
    input wire logic       rx_state_out,
    input wire logic       calibrating_out,
    input wire logic       settle_done_event_out,
    input wire logic       offset_cancel_loop_run_out,
    input wire logic       lock_release_out,
    input wire logic       start_of_frame_event_out,
    input wire logic       packet_received_event_out,
    input wire logic [3:0] analog_baseband_bandwidth_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    a_entry_calibrates: assert property (
        receive_entry_command_in |=> calibrating_out && state_out == 2'h2) else $error("no cal");
    a_ready_in_rx: assert property (
        settle_done_event_out |-> state_out == 2'h3 && rx_state_out) else $error("ready early");
    a_ready_one_pulse: assert property (
        settle_done_event_out |=> !settle_done_event_out) else $error("ready too long");
    a_rx_holds: assert property (
        rx_state_out && !receive_entry_command_in && !cmd_idle_in && !cmd_phy_standby_in
        |=> rx_state_out) else $error("rx left");
    a_sof_after_match: assert property (
        start_of_frame_event_out |-> $past(sync_match_in) && $past(sof_event_enable_in))
        else $error("stray sof");
    a_no_pkt_serial: assert property (
        packet_received_event_out |-> !$past(serial_data_port_en_in)) else $error("pkt event");
    a_lock_release: assert property (
        lock_release_out |-> $past(bit_strobe_in) && !$past(sync_match_in)) else $error("lock");
    a_ocl_cal_run: assert property (
        calibrating_out |-> offset_cancel_loop_run_out) else $error("ocl off");
    a_bw_held: assert property (
        !$stable(analog_baseband_bandwidth_out) |-> $past(cmd_phy_standby_in))
        else $error("bw early");
endmodule // frsc_rx_seq_chk
bind frsc_rx_seq frsc_rx_seq_chk u_chk (.*);
`default_nettype wire

/* frsc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module frsc_host_model (
    input  wire logic       sys_clk_in,
    output var  logic [9:0] addr_out,
    output var  logic [7:0] wdata_out,
    output var  logic       wr_out,
    output var  logic       rd_out,
    output var  logic [2:0] cmd_out
);
    initial {addr_out, wdata_out, wr_out, rd_out, cmd_out} = '0;
    // Strobes last one cycle; the edge after release passes before the next
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge sys_clk_in) #1 {addr_out, wdata_out, wr_out} = {a, d, 1'b1};
        @(posedge sys_clk_in) #1 wr_out = 1'b0;
    endtask
    task automatic rd(input logic [9:0] a);
        @(posedge sys_clk_in) #1 {addr_out, rd_out} = {a, 1'b1};
        @(posedge sys_clk_in) #1 rd_out = 1'b0;
    endtask
    // Bit 0 entry, bit 1 idle, bit 2 standby
    task automatic cmd(input logic [2:0] c);
        @(posedge sys_clk_in) #1 cmd_out = c;
        @(posedge sys_clk_in) #1 cmd_out = 3'h0;
    endtask
endmodule // frsc_host_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        sys_clk_in = 0, rst_in = 1, wr, rd, rvalid, rx, cal, done, offset_cancel_loop, lrel, sof, frm;
    logic        ser = 0, sofen = 0, pre = 0, sm = 0, bs = 0, pd = 0, pkt, psr, ssr;
    logic [9:0]  addr;
    logic [7:0]  wdata, rdata, pdb, expq[$], r[4];
    logic [2:0]  cmd, f2;
    logic [1:0]  st, f1;
    logic [3:0]  abw;
    logic [10:0] khz;
    logic [15:0] rate;
    logic [9:0]  ofs[9] = '{10'h109, 10'h10b, 10'h13e, 10'h30e, 10'h30f, 10'h389, 10'h38b,
                            10'h39b, 10'h000};
    int          num_errors = 0, samples_checked = 0, n;
    always #5 sys_clk_in = ~sys_clk_in;
    frsc_host_model u_frsc_host_model (.sys_clk_in(sys_clk_in), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .cmd_out(cmd));
    frsc_rx_seq #(.US_CYCLES(4)) u_frsc_rx_seq (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .receive_entry_command_in(cmd[0]),
        .cmd_idle_in(cmd[1]), .cmd_phy_standby_in(cmd[2]), .serial_data_port_en_in(ser),
        .sof_event_enable_in(sofen), .preamble_qualified_in(pre), .sync_match_in(sm),
        .bit_strobe_in(bs), .packet_done_in(pd), .state_out(st), .rx_state_out(rx),
        .calibrating_out(cal), .settle_done_event_out(done), .offset_cancel_loop_run_out(offset_cancel_loop),
        .preamble_search_out(psr), .sync_search_out(ssr), .lock_release_out(lrel),
        .start_of_frame_event_out(sof), .framing_sync_output_out(frm),
        .packet_received_event_out(pkt), .analog_baseband_bandwidth_out(abw),
        .analog_bb_bw_khz_out(khz), .channel_filter_first_bw_out(f1),
        .channel_filter_second_bw_out(f2), .post_discriminator_bandwidth_out(pdb),
        .bit_recovery_rate_out(rate));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Selector 0 waits for the ready event, 1 for a lock release
    task automatic wait_on(input bit sel, input int lim);
        n = 0;
        while ((sel ? lrel : done) !== 1'b1 && n < lim) begin
            @(posedge sys_clk_in) #1 n++;
        end
        if (n == lim) begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk_in) #1;
    endtask
    always @(posedge sys_clk_in) if (rvalid) check(rdata, expq.pop_front());
    initial begin
        void'($urandom(32'h0722_e54e));
        tick(5);
        rst_in = 0;
        foreach (ofs[i]) begin
            expq.push_back(i == 0 ? 8'hc0 : 8'h00);
            u_frsc_host_model.rd(ofs[i]);
        end
        foreach (r[i]) r[i] = 8'($urandom);
        u_frsc_host_model.wr(10'h30e, r[0]);
        u_frsc_host_model.wr(10'h30f, r[1]);
        u_frsc_host_model.wr(10'h389, r[2]);
        u_frsc_host_model.wr(10'h38b, r[3]);
        expq.push_back(r[0]);
        u_frsc_host_model.rd(10'h30e);
        check(rate, {r[0], r[1]});
        check(f1, r[2][1:0]);
        check(f2, r[2][4:2]);
        check(pdb, r[3]);
        $display("test registers done");
        u_frsc_host_model.wr(10'h13e, 8'h03);
        u_frsc_host_model.wr(10'h10b, 8'h76);
        u_frsc_host_model.cmd(3'h1);
        wait_on(0, 3000);
        check(n >= 2654 && n <= 2662, 1);
        check(st, 2'h3);
        tick(8);
        check({cal, offset_cancel_loop}, 2'b00);
        ser = 1;
        sofen = 1'($urandom);
        pre = 1;
        tick(1);
        pre = 0;
        tick(2);
        bs = 1;
        wait_on(1, 40);
        bs = 0;
        check(n, 32);
        pre = 1;
        tick(1);
        {pre, sm} = 2'b01;
        tick(1);
        {sm, pd} = 2'b01;
        check({sof, frm}, {sofen, 1'b1});
        tick(1);
        pd = 0;
        tick(1);
        check({pkt, frm, rx}, 3'b011);
        $display("test fsk receive done");
        ser = 0;
        u_frsc_host_model.wr(10'h13e, 8'h00);
        u_frsc_host_model.wr(10'h10b, 8'h00);
        u_frsc_host_model.cmd(3'h1);
        wait_on(0, 1000);
        check(n >= 766 && n <= 774, 1);
        tick(8);
        check(offset_cancel_loop, 1);
        sofen = !sofen;
        check({psr, ssr}, 2'b10);
        pre = 1;
        tick(1);
        {pre, sm} = 2'b01;
        tick(1);
        {sm, pd} = 2'b01;
        check({sof, frm, psr, ssr}, {sofen, 3'b001});
        tick(1);
        pd = 0;
        check(pkt, 1);
        u_frsc_host_model.wr(10'h39b, 8'h0e);
        check(abw, 4'h0);
        u_frsc_host_model.cmd(3'h2);
        u_frsc_host_model.cmd(3'h4);
        tick(2);
        check({abw, khz}, {4'he, 11'd1126});
        $display("test packet and bandwidth done");
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
